/* File: rtl/spbm_pkg.sv */
// package: register offsets, field positions, reset values and carrier types for the serial block
package spbm_pkg;
   // ------------------------------------------------------------
   // register offsets (special function register space)
   // ------------------------------------------------------------
   localparam logic [7:0] IO_REMAP_CTRL_OFS = 8'he1;   // pin remap register
   localparam logic [7:0] P1_STATUS_OFS     = 8'he2;   // port 1 interrupt/status register
   localparam logic [7:0] P1_DATA_OFS       = 8'he3;   // port 1 data buffer
   localparam logic [7:0] P1_BAUD_LO_OFS    = 8'he4;   // port 1 reload low byte
   localparam logic [7:0] P1_BAUD_HI_OFS    = 8'he5;   // port 1 reload high byte
   localparam logic [7:0] P1_FINE_OFS       = 8'he6;   // port 1 fine adjust (low nibble)
   localparam logic [7:0] P0_BAUD_LO_OFS    = 8'he7;   // port 0 reload low byte
   localparam logic [7:0] P0_BAUD_HI_OFS    = 8'he8;   // port 0 reload high byte
   localparam logic [7:0] P0_FINE_OFS       = 8'he9;   // port 0 fine adjust (low nibble)
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int REMAP_P0_BIT  = 3;   // port 0 alternate pins
   localparam int REMAP_P1_BIT  = 4;   // port 1 alternate pins
   localparam int ST_TXEMPTY    = 0;   // transmit empty flag
   localparam int ST_RXAVAIL    = 1;   // receive available flag / receive enable
   localparam int ST_RXOVR      = 2;   // receive overrun flag
   localparam int ST_COLL       = 3;   // collision flag / detect enable
   localparam int ST_IEN_LO     = 4;   // lowest interrupt enable bit
   // ------------------------------------------------------------
   // reset values and counts
   // ------------------------------------------------------------
   localparam logic [7:0]  REMAP_RST   = 8'h00;   // both ports on default pins
   localparam logic [15:0] BAUD_RST    = 16'h0000; // reload after reset
   localparam logic [3:0]  FINE_RST    = 4'h0;    // no fine trim after reset
   localparam int          OVERSAMPLE  = 16;      // ticks per bit
   localparam int          FINE_GROUP  = 16;      // bit periods per trim group
   localparam int          FIFO_DEPTH  = 16;      // transmit fifo words
   // ------------------------------------------------------------
   // carrier types
   // ------------------------------------------------------------
   typedef struct packed {
      logic       wr;    // write strobe
      logic       rd;    // read strobe
      logic [7:0] addr;  // register address
      logic [7:0] wdata; // write data
   } spbm_sfr_t;
   typedef struct packed {
      logic p0Rx;        // port 0 receive pad
      logic p1Rx;        // port 1 receive pad
   } spbm_rxpins_t;
endpackage : spbm_pkg

/* File: rtl/spbm_top.sv */
// serial block: port 1 status, baud generators, transmit fifo and pin remapping
`timescale 1ns/100ps

// ------------------------------------------------------------
// fifo with valid/ready on both sides
// ------------------------------------------------------------
module spbm_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,      // core clock
   input  wire logic             rstN,     // synchronised reset
   input  wire logic [WIDTH-1:0] inData,   // fill data
   input  wire logic             inValid,  // fill valid
   output logic                  inReady,  // room available
   output logic      [WIDTH-1:0] outData,  // drain data
   output logic                  outValid, // word available
   input  wire logic             outReady  // drain accepts
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];         // storage
   logic [AW-1:0]    wp;                  // write pointer
   logic [AW-1:0]    rp;                  // read pointer
   logic [AW:0]      cnt;                 // fill level
   logic             doW;                 // accepted write
   logic             doR;                 // accepted read
   assign inReady  = (cnt != (AW+1)'(DEPTH));
   assign outValid = (cnt != '0);
   assign outData  = mem[rp];
   assign doW      = inValid && inReady;
   assign doR      = outValid && outReady;
   // storage write
   always_ff @(posedge clk) begin
      if (doW) begin
         mem[wp] <= inData;
      end
   end
   // pointers and level
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         wp  <= '0;
         rp  <= '0;
         cnt <= '0;
      end else begin
         if (doW) wp <= AW'(wp + 1'b1);
         if (doR) rp <= AW'(rp + 1'b1);
         cnt <= (AW+1)'(cnt + doW - doR);
      end
   end
endmodule : spbm_fifo

// ------------------------------------------------------------
// baud generator: reload divider plus spread fine trim
// ------------------------------------------------------------
module spbm_baud (
   input  wire logic        clk,     // core clock
   input  wire logic        rstN,    // synchronised reset
   input  wire logic [15:0] reload,  // divider reload value
   input  wire logic [3:0]  fine,    // extra clocks per 16 bit periods
   output logic             tick     // one pulse per oversample tick
);
   import spbm_pkg::*;
   logic [15:0] div;      // divider count
   logic [3:0]  sub;      // tick within bit
   logic [3:0]  bitIdx;   // bit within trim group
   logic        stretch;  // this bit takes one extra clock
   logic        extra;    // extra clock pending
   // spread: bit k of group gets an extra clock when k < fine
   assign stretch = (bitIdx < fine);
   // counting: every reload code is legal, 0 divides by one
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         div <= '0; sub <= '0; bitIdx <= '0; extra <= 1'b0; tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (extra) begin
            extra <= 1'b0;                       // inserted trim clock
         end else if (div >= reload) begin
            div  <= '0;
            tick <= 1'b1;                        // divide by reload+1
            sub  <= 4'(sub + 1'b1);
            if (sub == 4'(OVERSAMPLE-1)) begin
               bitIdx <= 4'(bitIdx + 1'b1);
               extra  <= stretch;                // spread over 16 bits
            end
         end else begin
            div <= 16'(div + 1'b1);
         end
      end
   end
endmodule : spbm_baud

// ------------------------------------------------------------
// top
// ------------------------------------------------------------
// Functional notes
// - overrun flag bit 2 on unread data collision
// - receive available flag bit 1 on character
// - writing one to bit 1 enables receiver
// - transmit empty flag bit 0 when room
// - full 16-bit reload, all codes valid
// - 4-bit fine adjust trims baud rate
// - remap bit 3 moves port 0 transmit pin, receive stays on rxPads.p0Rx
// - alternate port 0 overrides pulse outputs three/four
// - remap bit 4 moves port 1 transmit pin, receive stays on rxPads.p1Rx
// - bits 7..4 enable the four interrupts
// - bit 3 collision flag and detect enable
module spbm_top (
   input  wire logic                  core_clk,      // 20 MHz system clock
   input  wire logic                  nrst,          // async reset, active low
   input  wire spbm_pkg::spbm_sfr_t   sfr,           // register access strobes
   output logic [7:0]                 sfrRdata,      // register read data
   input  wire spbm_pkg::spbm_rxpins_t rxPads,       // receive pad levels
   input  wire logic                  p0TxBit,       // port 0 transmitter line
   input  wire logic                  pulseOutThree, // pulse output three
   input  wire logic                  pulseOutFour,  // pulse output four
   output logic                       port0Tick,     // port 0 oversample tick
   output logic                       port0ReceiveLine, // routed port 0 receive
   output logic                       padP31,        // default port 0 tx pad
   output logic                       padP23,        // alt port 0 tx / pulse three
   output logic                       padP24Oe,      // p2.4 drive enable, low = drive
   output logic                       padP24,        // pulse four when driven
   output logic                       padP13,        // default port 1 tx pad
   output logic                       padPin40,      // alt port 1 tx pad
   output logic                       port1Irq       // port 1 interrupt request
);
   import spbm_pkg::*;
   // ------------------------------------------------------------
   // reset synchroniser
   // ------------------------------------------------------------
   logic rstMeta;   // first stage
   logic rstN;      // released reset
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rstMeta <= 1'b0;
         rstN    <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstN    <= rstMeta;
      end
   end
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0]  ioRemapCtrl;   // pin remap register
   logic [3:0]  irqEnable;     // interrupt enables
   logic        collEnable;    // collision detection on
   logic        rxEnable;      // receiver active
   logic [15:0] p1Reload;      // port 1 baud reload
   logic [3:0]  p1Fine;        // port 1 fine trim
   logic [15:0] p0Reload;      // port 0 baud reload
   logic [3:0]  p0Fine;        // port 0 fine trim
   logic        wrStatus;      // status write this cycle
   assign wrStatus = sfr.wr && (sfr.addr == P1_STATUS_OFS);
   // control register writes
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         ioRemapCtrl <= REMAP_RST;
         irqEnable <= '0; collEnable <= 1'b0; rxEnable <= 1'b0;
         p1Reload <= BAUD_RST; p1Fine <= FINE_RST;
         p0Reload <= BAUD_RST; p0Fine <= FINE_RST;
      end else if (sfr.wr) begin
         unique case (sfr.addr)
            IO_REMAP_CTRL_OFS: ioRemapCtrl <= sfr.wdata;
            P1_STATUS_OFS: begin
               irqEnable  <= sfr.wdata[7:ST_IEN_LO];
               collEnable <= sfr.wdata[ST_COLL];
               if (sfr.wdata[ST_RXAVAIL]) rxEnable <= 1'b1;
            end
            P1_BAUD_LO_OFS: p1Reload[7:0]  <= sfr.wdata;
            P1_BAUD_HI_OFS: p1Reload[15:8] <= sfr.wdata;
            P1_FINE_OFS:    p1Fine <= sfr.wdata[3:0];
            P0_BAUD_LO_OFS: p0Reload[7:0]  <= sfr.wdata;
            P0_BAUD_HI_OFS: p0Reload[15:8] <= sfr.wdata;
            P0_FINE_OFS:    p0Fine <= sfr.wdata[3:0];
            default: ;                                        // unmapped: ignored
         endcase
      end
   end
   // ------------------------------------------------------------
   // baud generators
   // ------------------------------------------------------------
   logic p1Tick;   // port 1 oversample tick
   spbm_baud u_baud0 (.clk(core_clk), .rstN(rstN), .reload(p0Reload), .fine(p0Fine),
                      .tick(port0Tick));
   spbm_baud u_baud1 (.clk(core_clk), .rstN(rstN), .reload(p1Reload), .fine(p1Fine),
                      .tick(p1Tick));
   // ------------------------------------------------------------
   // pin mapping
   // ------------------------------------------------------------
   logic p0Alt;        // port 0 on alternate pins
   logic p1Alt;        // port 1 on alternate pins
   logic p1RxLine;     // routed port 1 receive
   logic p1TxLine;     // port 1 transmit line
   assign p0Alt = ioRemapCtrl[REMAP_P0_BIT];
   assign p1Alt = ioRemapCtrl[REMAP_P1_BIT];
   // port 0: default tx p3.1, alternate tx p2.3 with p2.4 released; receive always from rxPads.p0Rx
   assign port0ReceiveLine = rxPads.p0Rx;
   assign padP31   = p0Alt ? 1'b1 : p0TxBit;
   assign padP23   = p0Alt ? p0TxBit : pulseOutThree;
   assign padP24Oe = p0Alt;                                  // released as input
   assign padP24   = pulseOutFour;
   // port 1: default tx p1.3, alternate tx pin 40; receive always from rxPads.p1Rx
   assign p1RxLine = rxPads.p1Rx;
   assign padP13   = p1Alt ? 1'b1 : p1TxLine;
   assign padPin40 = p1Alt ? p1TxLine : 1'b1;
   // ------------------------------------------------------------
   // port 1 transmit path through fifo
   // ------------------------------------------------------------
   logic       fifoInReady;   // fifo has room
   logic [7:0] txWord;        // head word
   logic       txValid;       // head valid
   logic       txTake;        // shifter loads head
   logic [9:0] txShift;       // frame shifter
   logic [3:0] txBits;        // bits left
   logic [3:0] txSub;         // ticks within bit
   logic       collision;     // line disagreed with driven bit
   logic       wrData;        // data buffer write
   assign wrData  = sfr.wr && (sfr.addr == P1_DATA_OFS);
   assign txTake  = txValid && (txBits == '0);
   assign p1TxLine = (txBits == '0) ? 1'b1 : txShift[0];
   spbm_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txfifo (
      .clk(core_clk), .rstN(rstN), .inData(sfr.wdata), .inValid(wrData),
      .inReady(fifoInReady), .outData(txWord), .outValid(txValid), .outReady(txTake));
   // transmit shifter, collision aborts it
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         txShift <= '1; txBits <= '0; txSub <= '0;
      end else if (collision) begin
         txBits <= '0;
      end else if (txTake) begin
         txShift <= {1'b1, txWord, 1'b0};
         txBits  <= 4'd10;
         txSub   <= '0;
      end else if (p1Tick && txBits != '0) begin
         txSub <= 4'(txSub + 1'b1);
         if (txSub == 4'(OVERSAMPLE-1)) begin
            txShift <= {1'b1, txShift[9:1]};
            txBits  <= 4'(txBits - 1'b1);
         end
      end
   end
   // collision: mid-bit line differs from driven bit
   assign collision = collEnable && p1Tick && (txBits != '0) &&
                      (txSub == 4'(OVERSAMPLE/2)) && (p1RxLine != txShift[0]);
   // ------------------------------------------------------------
   // port 1 receiver
   // ------------------------------------------------------------
   logic [3:0] rxSub;      // ticks within bit
   logic [3:0] rxBits;     // bits left, 0 = idle
   logic [7:0] rxShift;    // assembling character
   logic [7:0] rxBuf;      // receive data buffer
   logic       rxDone;     // character complete
   logic       rdData;     // data buffer read
   assign rdData = sfr.rd && (sfr.addr == P1_DATA_OFS);
   // start detect, mid-bit sampling, stop bit completes
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         rxSub <= '0; rxBits <= '0; rxShift <= '0; rxDone <= 1'b0;
      end else begin
         rxDone <= 1'b0;
         if (rxBits == '0) begin
            if (rxEnable && p1Tick && !p1RxLine) begin
               rxBits <= 4'd10;
               rxSub  <= '0;
            end
         end else if (p1Tick) begin
            rxSub <= 4'(rxSub + 1'b1);
            if (rxSub == 4'(OVERSAMPLE/2 - 2)) begin
               rxBits <= 4'(rxBits - 1'b1);
               if (rxBits == 4'd10 && p1RxLine) rxBits <= '0; // false start
               else if (rxBits > 4'd1) rxShift <= {p1RxLine, rxShift[7:1]};
               else rxDone <= 1'b1;
            end
         end
      end
   end
   // ------------------------------------------------------------
   // status flags: set wins over clear
   // ------------------------------------------------------------
   logic rxOverrunFlag;     // bit 2
   logic rxAvailableFlag;   // bit 1
   logic collisionFlag;     // bit 3
   logic txEmptyFlag;       // bit 0
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         rxBuf <= '0; rxOverrunFlag <= 1'b0; rxAvailableFlag <= 1'b0; collisionFlag <= 1'b0;
      end else begin
         if (rxDone) rxBuf <= rxShift;
         if (rxDone && rxAvailableFlag) rxOverrunFlag <= 1'b1;
         else if (rdData || (wrStatus && !sfr.wdata[ST_RXOVR]))
            rxOverrunFlag <= 1'b0;
         if (rxDone) rxAvailableFlag <= 1'b1;
         else if (rdData || (wrStatus && !sfr.wdata[ST_RXAVAIL]))
            rxAvailableFlag <= 1'b0;
         if (collision) collisionFlag <= 1'b1;
         else if (wrStatus && !sfr.wdata[ST_COLL]) collisionFlag <= 1'b0;
      end
   end
   assign txEmptyFlag = fifoInReady;
   assign port1Irq = |(irqEnable & {collisionFlag, rxOverrunFlag,
                                    rxAvailableFlag, txEmptyFlag});
   // ------------------------------------------------------------
   // read mux, registered
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         sfrRdata <= '0;
      end else begin
         unique case (sfr.addr)
            IO_REMAP_CTRL_OFS: sfrRdata <= ioRemapCtrl;
            P1_STATUS_OFS: sfrRdata <= {irqEnable, collisionFlag, rxOverrunFlag,
                                        rxAvailableFlag, txEmptyFlag};
            P1_DATA_OFS:    sfrRdata <= rxBuf;
            P1_BAUD_LO_OFS: sfrRdata <= p1Reload[7:0];
            P1_BAUD_HI_OFS: sfrRdata <= p1Reload[15:8];
            P1_FINE_OFS:    sfrRdata <= {4'h0, p1Fine};
            P0_BAUD_LO_OFS: sfrRdata <= p0Reload[7:0];
            P0_BAUD_HI_OFS: sfrRdata <= p0Reload[15:8];
            P0_FINE_OFS:    sfrRdata <= {4'h0, p0Fine};
            default:        sfrRdata <= 8'h00;
         endcase
      end
   end
endmodule : spbm_top

/* File: tb/spbm_props.sv */
// checker: port-level properties of the serial block
`timescale 1ns/100ps
module spbm_props (
   input wire logic                   core_clk,         // clock
   input wire logic                   nrst,             // raw reset
   input wire spbm_pkg::spbm_sfr_t    sfr,              // strobes
   input wire logic [7:0]             sfrRdata,         // read data
   input wire spbm_pkg::spbm_rxpins_t rxPads,           // rx pads
   input wire logic                   p0TxBit,          // port 0 tx
   input wire logic                   pulseOutThree,    // pulse three
   input wire logic                   pulseOutFour,     // pulse four
   input wire logic                   port0Tick,        // tick
   input wire logic                   port0ReceiveLine, // routed rx
   input wire logic                   padP31,           // pad
   input wire logic                   padP23,           // pad
   input wire logic                   padP24Oe,         // enable
   input wire logic                   padP24,           // pad
   input wire logic                   padP13,           // pad
   input wire logic                   padPin40,         // pad
   input wire logic                   port1Irq          // irq
);
   import spbm_pkg::*;
   logic [7:0]  remap; // remap shadow
   logic [3:0]  ien;   // enable shadow
   logic [15:0] rl;    // port 0 reload
   logic [3:0]  fn;    // port 0 fine trim
   logic [16:0] gap;   // clocks since last tick
   logic [1:0]  stab;  // ticks since last baud write
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // ----------------------------------------
   // shadows of written registers
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         remap <= 8'h00;
         ien <= 4'h0;
         rl <= 16'h0000;
         fn <= 4'h0;
      end else if (sfr.wr) begin
         case (sfr.addr)
            IO_REMAP_CTRL_OFS: remap <= sfr.wdata;
            P1_STATUS_OFS: ien <= sfr.wdata[7:4];
            P0_BAUD_LO_OFS: rl[7:0] <= sfr.wdata;
            P0_BAUD_HI_OFS: rl[15:8] <= sfr.wdata;
            P0_FINE_OFS: fn <= sfr.wdata[3:0];
            default: ;
         endcase
      end
   end
   // tick spacing, settled after a baud write
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         gap <= 17'h0;
         stab <= 2'h0;
      end else begin
         gap <= port0Tick ? 17'h1 : gap + 17'h1;
         if (sfr.wr && sfr.addr inside {P0_BAUD_LO_OFS, P0_BAUD_HI_OFS, P0_FINE_OFS})
            stab <= 2'h0;
         else if (port0Tick && stab != 2'h2)
            stab <= stab + 2'h1;
      end
   end
   a_p0_tx_route: assert property (
      remap[REMAP_P0_BIT] ? padP23 == p0TxBit : padP31 == p0TxBit) else $error("tx0 pad");
   a_alt_override: assert property (
      remap[REMAP_P0_BIT] |-> padP24Oe && padP23 == p0TxBit) else $error("alt pins");
   a_pulse_keep: assert property (
      !remap[REMAP_P0_BIT] |-> !padP24Oe && padP23 == pulseOutThree && padP24 == pulseOutFour)
      else $error("pulse pads");
   a_rx0_route: assert property (
      port0ReceiveLine == rxPads.p0Rx) else $error("rx0 route");
   a_remap_readback: assert property (
      sfr.rd && sfr.addr == IO_REMAP_CTRL_OFS |=> sfrRdata == remap) else $error("remap read");
   a_irq_gated: assert property (
      port1Irq |-> ien != 4'h0) else $error("irq without enable");
   a_enable_read: assert property (
      sfr.rd && sfr.addr == P1_STATUS_OFS |=> sfrRdata[7:4] == ien) else $error("enable read");
   a_avail_cleared: assert property (
      sfr.rd && sfr.addr == P1_DATA_OFS ##2 sfr.rd && sfr.addr == P1_STATUS_OFS
      |=> !sfrRdata[ST_RXAVAIL]) else $error("avail not cleared");
   a_tick_gap: assert property (
      port0Tick && stab == 2'h2 |-> gap >= {1'b0, rl} + 17'h1
      && gap <= {1'b0, rl} + 17'h1 + (fn != 4'h0)) else $error("tick spacing");
   a_reset_quiet: assert property (disable iff (1'b0)
      !nrst |-> !port1Irq && !padP24Oe) else $error("reset outputs");
endmodule : spbm_props
bind spbm_top spbm_props spbm_props_inst (.core_clk(core_clk), .nrst(nrst), .sfr(sfr),
   .sfrRdata(sfrRdata), .rxPads(rxPads), .p0TxBit(p0TxBit), .pulseOutThree(pulseOutThree),
   .pulseOutFour(pulseOutFour), .port0Tick(port0Tick), .port0ReceiveLine(port0ReceiveLine),
   .padP31(padP31), .padP23(padP23), .padP24Oe(padP24Oe), .padP24(padP24), .padP13(padP13),
   .padPin40(padPin40), .port1Irq(port1Irq));

/* File: tb/spbm_remote.sv */
// far-side serial device: 8N1 sender and receiver, lsb first
`timescale 1ns/100ps
module spbm_remote #(
   parameter int BIT_NS = 1600 // bit period matched to the reload in use
) (
   input  wire logic lineIn,   // device transmit pad
   output logic      lineOut,  // device receive pad, idles high
   output logic [7:0] lastByte, // last character taken
   output int        rxCount   // characters taken
);
   initial begin
      lineOut = 1'b1;
      rxCount = 0;
   end
   // one 8N1 frame
   task automatic send(input logic [7:0] d);
      #10;
      lineOut = 1'b0;
      #(BIT_NS);
      for (int i = 0; i < 8; i++) begin
         lineOut = d[i];
         #(BIT_NS);
      end
      lineOut = 1'b1;
      #(BIT_NS);
   endtask : send
   // receiver: sample each bit mid-way
   always begin
      @(negedge lineIn);
      #(BIT_NS / 2);
      for (int i = 0; i < 8; i++) begin
         #(BIT_NS);
         lastByte[i] = lineIn;
      end
      #(BIT_NS);
      rxCount++;
   end
endmodule : spbm_remote

/* File: tb/test_spbm_top.sv */
// testbench: register, pin, receive, transmit and baud scenarios
`timescale 1ns/100ps
module test_spbm_top;
   import spbm_pkg::*;
   logic         core_clk, nrst, p0TxBit, pulseOutThree, pulseOutFour, p0Rx, p1Rx, p1Alt;
   logic         port0Tick, port0ReceiveLine, padP31, padP23, padP24Oe, padP24, padP13;
   logic         padPin40, port1Irq;
   logic [7:0]   sfrRdata, rd, lastByte;
   logic [2:0]   pat;
   spbm_sfr_t    sfr;
   spbm_rxpins_t rxPads;
   int           err_total, num_checks, cyc, rxCount, c;
   assign rxPads = '{p0Rx, p1Rx};
   spbm_top spbm_top_inst (.core_clk(core_clk), .nrst(nrst), .sfr(sfr), .sfrRdata(sfrRdata),
      .rxPads(rxPads), .p0TxBit(p0TxBit), .pulseOutThree(pulseOutThree),
      .pulseOutFour(pulseOutFour), .port0Tick(port0Tick), .port0ReceiveLine(port0ReceiveLine),
      .padP31(padP31), .padP23(padP23), .padP24Oe(padP24Oe), .padP24(padP24), .padP13(padP13),
      .padPin40(padPin40), .port1Irq(port1Irq));
   spbm_remote spbm_remote_inst (.lineIn(p1Alt ? padPin40 : padP13), .lineOut(p1Rx),
      .lastByte(lastByte), .rxCount(rxCount));
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // shared-pad inputs
   always @(posedge core_clk) begin
      pat <= pat + 3'h1;
      {p0Rx, pulseOutFour, pulseOutThree, p0TxBit} <= {^pat, pat};
   end
   // hang guard
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         results();
      end
   end
   task automatic chk(input logic [31:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, d);
      @(posedge core_clk);
      sfr <= '{1'b1, 1'b0, a, d};
      @(posedge core_clk);
      sfr.wr <= 1'b0;
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      @(posedge core_clk);
      sfr <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge core_clk);
      sfr.rd <= 1'b0;
      #1 rd = sfrRdata;
   endtask : rdr
   task automatic waitrx(input int n);
      for (int k = 0; k < 8000 && rxCount < n; k++) @(posedge core_clk);
      chk(rxCount, n);
   endtask : waitrx
   task automatic meas(input int n, output int t);
      int k;
      k = 0;
      t = 0;
      while (k <= n && t < 9000) begin
         @(posedge core_clk);
         #1 if (k > 0) t++;
         if (port0Tick === 1'b1) k++;
      end
   endtask : meas
   task automatic t_reset;
      rdr(IO_REMAP_CTRL_OFS); chk(rd, 8'h00);
      rdr(P1_STATUS_OFS); chk(rd, 8'h01);
      rdr(8'hf0); chk(rd, 8'h00);
      $display("test reset done");
   endtask : t_reset
   task automatic t_pins;
      wr(IO_REMAP_CTRL_OFS, 8'h08);
      rdr(IO_REMAP_CTRL_OFS); chk(rd, 8'h08);
      chk({padP24Oe, padP23}, {1'b1, p0TxBit});
      wr(IO_REMAP_CTRL_OFS, 8'h00);
      #1 chk({padP24Oe, padP24}, {1'b0, pulseOutFour});
      $display("test pins done");
   endtask : t_pins
   task automatic t_rx;
      wr(P1_BAUD_LO_OFS, 8'h01);
      wr(P1_BAUD_HI_OFS, 8'h00);
      wr(P1_FINE_OFS, 8'h00);
      spbm_remote_inst.send(8'h11);
      rdr(P1_STATUS_OFS); chk(rd[ST_RXAVAIL], 1'b0);
      wr(P1_STATUS_OFS, 8'h02);
      spbm_remote_inst.send(8'ha5);
      rdr(P1_STATUS_OFS); chk(rd[2:1], 2'b01);
      rdr(P1_DATA_OFS); chk(rd, 8'ha5);
      rdr(P1_STATUS_OFS); chk(rd[2:1], 2'b00);
      spbm_remote_inst.send(8'h3c);
      spbm_remote_inst.send(8'hc3);
      rdr(P1_STATUS_OFS); chk(rd[2:1], 2'b11);
      rdr(P1_DATA_OFS); chk(rd, 8'hc3);
      rdr(P1_STATUS_OFS); chk(rd[2:1], 2'b00);
      wr(P1_STATUS_OFS, 8'h22);
      spbm_remote_inst.send(8'h5a);
      #1 chk(port1Irq, 1'b1);
      wr(P1_STATUS_OFS, 8'h20);
      #1 chk(port1Irq, 1'b0);
      wr(P1_STATUS_OFS, 8'h0a);
      wr(P1_DATA_OFS, 8'h55);
      repeat (400) @(posedge core_clk);
      rdr(P1_STATUS_OFS); chk(rd[ST_COLL], 1'b1);
      wr(P1_STATUS_OFS, 8'h02);
      $display("test receive done");
   endtask : t_rx
   task automatic t_tx;
      c = rxCount;
      wr(P1_DATA_OFS, 8'h3c);
      waitrx(c + 1);
      chk(lastByte, 8'h3c);
      c = rxCount;
      for (int i = 0; i < 18; i++) wr(P1_DATA_OFS, i[7:0]);
      rdr(P1_STATUS_OFS); chk(rd[ST_TXEMPTY], 1'b0);
      waitrx(c + 16);
      chk(lastByte, 8'h0f);
      repeat (700) @(posedge core_clk);
      rdr(P1_STATUS_OFS); chk(rd[ST_TXEMPTY], 1'b1);
      wr(IO_REMAP_CTRL_OFS, 8'h10);
      p1Alt = 1'b1;
      c = rxCount;
      wr(P1_DATA_OFS, 8'h96);
      waitrx(c + 1);
      chk(lastByte, 8'h96);
      $display("test transmit done");
   endtask : t_tx
   task automatic t_baud;
      int t;
      wr(P0_BAUD_LO_OFS, 8'h03);
      wr(P0_BAUD_HI_OFS, 8'h00);
      meas(300, t);
      meas(256, t);
      chk(t, 1024);
      wr(P0_FINE_OFS, 8'h05);
      meas(300, t);
      meas(256, t);
      chk(t, 1029);
      wr(P0_FINE_OFS, 8'h00);
      wr(P0_BAUD_LO_OFS, 8'h00);
      wr(P0_BAUD_HI_OFS, 8'h01);
      meas(2, t);
      meas(4, t);
      chk(t, 1028);
      $display("test baud done");
   endtask : t_baud
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results
   initial begin
      {nrst, p1Alt, pat, p0TxBit, pulseOutThree, pulseOutFour, p0Rx} = '0;
      sfr = '0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge core_clk);
      t_reset();
      t_pins();
      t_rx();
      t_tx();
      t_baud();
      results();
   end
endmodule : test_spbm_top
